// *** rtl/s2va_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "s2va_defs.svh"
// attribute and timing registers of the second video stream
module s2va_bank
   import s2va_pkg::*;
#(
   parameter int ADDR_W = 12  // register address width
) (
   input  wire logic                   core_clk_in,   // 50 MHz clock
   input  wire logic                   reset_n_in,    // async reset
   input  wire logic [ADDR_W-1:0]      reg_addr_in,   // byte address
   input  wire logic [31:0]            reg_wdata_in,  // write data
   input  wire logic                   reg_wr_in,     // write strobe
   input  wire logic                   reg_rd_in,     // read strobe
   output logic      [31:0]            reg_rdata_out, // read data
   input  wire logic [`S2VA_M_W-1:0]   m_calc_in,     // computed m
   output logic                        vsync_pol_out, // vsync level
   output logic                        hsync_pol_out, // hsync level
   output logic      [`S2VA_SW_W-1:0]  hsync_width_out,  // clocks
   output logic      [`S2VA_SW_W-1:0]  vsync_width_out,  // lines
   output logic      [`S2VA_RES_W-1:0] active_width_out, // pixels
   output logic      [`S2VA_RES_W-1:0] active_height_out, // lines
   output logic      [`S2VA_RES_W-1:0] h_offset_out,  // start clocks
   output logic      [`S2VA_RES_W-1:0] v_offset_out,  // start lines
   output logic      [`S2VA_ATA_W-1:0] attr_byte_a_out, // byte a
   output logic      [`S2VA_ATA_W-1:0] attr_byte_b_out, // byte b
   output logic      [`S2VA_M_W-1:0]   clock_ratio_m_out, // m reg
   output logic      [`S2VA_M_W-1:0]   m_link_out,    // m in use
   output logic      [`S2VA_TU_W-1:0]  tu_size_out    // unit size
);
   // the decoder compares the full bank offset, so it needs 12 bits
   if (ADDR_W < `S2VA_OFS_W) begin : g_addr_w_chk
      $error("s2va_bank: ADDR_W too small for the bank");
   end

   localparam s2va_bank_t ST_RST = '{
      tu:      `S2VA_TU_RST,
      default: '0
   };

   s2va_bank_t st_ff;   // whole bank
   s2va_bank_t nxt_st;  // next bank
   s2va_acc_if acc ();  // decoded access

   // address decode, strobes gated by a hit
   s2va_addr_dec #(
      .ADDR_W   (ADDR_W)
   ) u_dec (
      .addr_in  (reg_addr_in),
      .wr_in    (reg_wr_in),
      .rd_in    (reg_rd_in),
      .wdata_in (reg_wdata_in),
      .acc      (acc)
   );

   // read word of one register, undefined bits forced low
   function automatic logic [31:0] rd_word(input s2va_bank_t s,
                                           input logic [3:0] i);
      unique case (i)
         `S2VA_IDX_POL:  rd_word = 32'({s.vpol, s.hpol});
         `S2VA_IDX_HSW:  rd_word = 32'(s.hsw);
         `S2VA_IDX_VSW:  rd_word = 32'(s.vsw);
         `S2VA_IDX_HRES: rd_word = 32'(s.hres);
         `S2VA_IDX_VRES: rd_word = 32'(s.vres);
         `S2VA_IDX_HST:  rd_word = 32'(s.hst);
         `S2VA_IDX_VST:  rd_word = 32'(s.vst);
         `S2VA_IDX_ATA:  rd_word = 32'(s.ata);
         `S2VA_IDX_ATB:  rd_word = 32'(s.atb);
         `S2VA_IDX_M:    rd_word = 32'(s.m);
         `S2VA_IDX_TU:   rd_word = 32'(s.tu);
         default:        rd_word = 32'h0000_0000;
      endcase
   endfunction

   // next state: writes land in the field, reads load the answer
   always_comb begin
      nxt_st       = st_ff;
      nxt_st.rdata = 32'h0000_0000; // answer stands one cycle only
      if (acc.wr) begin
         unique case (acc.idx)
            `S2VA_IDX_POL: begin
               nxt_st.vpol = acc.wdata[`S2VA_VPOL_BIT];
               nxt_st.hpol = acc.wdata[`S2VA_HPOL_BIT];
            end
            `S2VA_IDX_HSW: begin
               nxt_st.hsw = acc.wdata[`S2VA_SW_W-1:0];
            end
            `S2VA_IDX_VSW: begin
               nxt_st.vsw = acc.wdata[`S2VA_SW_W-1:0];
            end
            `S2VA_IDX_HRES: begin
               nxt_st.hres = acc.wdata[`S2VA_RES_W-1:0];
            end
            `S2VA_IDX_VRES: begin
               nxt_st.vres = acc.wdata[`S2VA_RES_W-1:0];
            end
            `S2VA_IDX_HST: begin
               nxt_st.hst = acc.wdata[`S2VA_RES_W-1:0];
            end
            `S2VA_IDX_VST: begin
               nxt_st.vst = acc.wdata[`S2VA_RES_W-1:0];
            end
            `S2VA_IDX_ATA: begin
               nxt_st.ata = acc.wdata[`S2VA_ATA_W-1:0];
            end
            `S2VA_IDX_ATB: begin
               // bit 7 is not a field, so it is dropped here
               nxt_st.atb = acc.wdata[`S2VA_ATB_W-1:0];
            end
            `S2VA_IDX_M: begin
               // only software fills this; hardware m goes elsewhere
               nxt_st.m = acc.wdata[`S2VA_M_W-1:0];
            end
            `S2VA_IDX_TU: begin
               // low bit pinned to zero keeps the size even
               nxt_st.tu = {acc.wdata[`S2VA_TU_W-1:1], 1'b0};
            end
            default: begin
               // indices above the bank never carry a strobe
            end
         endcase
      end
      if (acc.rd) begin
         nxt_st.rdata = rd_word(st_ff, acc.idx);
      end
   end

   // bank register
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st_ff <= ST_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // m for the stream: programmed in sync mode, else computed
   s2va_mval_sel u_msel (
      .clk_in     (core_clk_in),
      .rst_n_in   (reset_n_in),
      .sync_in    (st_ff.ata[`S2VA_SYNC_BIT]),
      .m_reg_in   (st_ff.m),
      .m_calc_in  (m_calc_in),
      .m_link_out (m_link_out)
   );

   // all settings go straight from flip-flops to the framer
   assign reg_rdata_out     = st_ff.rdata;
   assign vsync_pol_out     = st_ff.vpol;
   assign hsync_pol_out     = st_ff.hpol;
   assign hsync_width_out   = st_ff.hsw;
   assign vsync_width_out   = st_ff.vsw;
   assign active_width_out  = st_ff.hres;
   assign active_height_out = st_ff.vres;
   assign h_offset_out      = st_ff.hst;
   assign v_offset_out      = st_ff.vst;
   assign attr_byte_a_out   = st_ff.ata;
   assign attr_byte_b_out   = {1'b0, st_ff.atb};
   assign clock_ratio_m_out = st_ff.m;
   assign tu_size_out       = st_ff.tu;

   // ---- checks on the bank's own behaviour ----
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!reset_n_in);

   // helper: write to a given offset this cycle
   function automatic logic wr_at(input logic [`S2VA_OFS_W-1:0] o);
      return reg_wr_in && (reg_addr_in == ADDR_W'(o));
   endfunction

   // helper: read from a given offset this cycle
   function automatic logic rd_at(input logic [`S2VA_OFS_W-1:0] o);
      return reg_rd_in && (reg_addr_in == ADDR_W'(o));
   endfunction

   sequence s_wr_pol;
      wr_at(`S2VA_OFS_POL);
   endsequence

   sequence s_rd_pol;
      rd_at(`S2VA_OFS_POL);
   endsequence

   property p_vpol;
      logic d;
      (s_wr_pol, d = reg_wdata_in[`S2VA_VPOL_BIT])
         |=> vsync_pol_out == d;
   endproperty
   a_vpol: assert property (p_vpol)
      else $error("vsync polarity not taken from write");

   property p_hpol;
      s_wr_pol ##1 s_rd_pol
         |=> reg_rdata_out[`S2VA_HPOL_BIT] ==
             $past(reg_wdata_in[`S2VA_HPOL_BIT], 2);
   endproperty
   a_hpol: assert property (p_hpol)
      else $error("hsync polarity readback wrong");

   property p_hsw;
      wr_at(`S2VA_OFS_HSW)
         |=> hsync_width_out == $past(reg_wdata_in[`S2VA_SW_W-1:0]);
   endproperty
   a_hsw: assert property (p_hsw)
      else $error("hsync width not taken from write");

   property p_vsw;
      wr_at(`S2VA_OFS_VSW)
         |=> vsync_width_out == $past(reg_wdata_in[`S2VA_SW_W-1:0]);
   endproperty
   a_vsw: assert property (p_vsw)
      else $error("vsync width not taken from write");

   property p_hres;
      wr_at(`S2VA_OFS_HRES)
         |=> active_width_out == $past(reg_wdata_in[`S2VA_RES_W-1:0]);
   endproperty
   a_hres: assert property (p_hres)
      else $error("active width not taken from write");

   property p_vres;
      !wr_at(`S2VA_OFS_VRES) |=> $stable(active_height_out);
   endproperty
   a_vres: assert property (p_vres)
      else $error("active height changed without a write");

   property p_hst;
      wr_at(`S2VA_OFS_HST)
         |=> h_offset_out == $past(reg_wdata_in[`S2VA_RES_W-1:0]);
   endproperty
   a_hst: assert property (p_hst)
      else $error("horizontal start not taken from write");

   property p_vst;
      wr_at(`S2VA_OFS_VST) ##1 rd_at(`S2VA_OFS_VST)
         |=> reg_rdata_out == 32'($past(reg_wdata_in[`S2VA_RES_W-1:0], 2));
   endproperty
   a_vst: assert property (p_vst)
      else $error("vertical start readback wrong");

   property p_ata;
      wr_at(`S2VA_OFS_ATA)
         |=> attr_byte_a_out == $past(reg_wdata_in[`S2VA_ATA_W-1:0]);
   endproperty
   a_ata: assert property (p_ata)
      else $error("attribute byte a not taken from write");

   property p_atb;
      wr_at(`S2VA_OFS_ATB)
         |=> attr_byte_b_out ==
             {1'b0, $past(reg_wdata_in[`S2VA_ATB_W-1:0])};
   endproperty
   a_atb: assert property (p_atb)
      else $error("attribute byte b wrong after write");

   property p_msync;
      attr_byte_a_out[`S2VA_SYNC_BIT]
         |=> m_link_out == $past(clock_ratio_m_out);
   endproperty
   a_msync: assert property (p_msync)
      else $error("sync mode does not use programmed m");

   property p_masync;
      !attr_byte_a_out[`S2VA_SYNC_BIT]
         |=> m_link_out == $past(m_calc_in);
   endproperty
   a_masync: assert property (p_masync)
      else $error("async mode does not use computed m");

   property p_mkeep;
      !wr_at(`S2VA_OFS_M) |=> $stable(clock_ratio_m_out);
   endproperty
   a_mkeep: assert property (p_mkeep)
      else $error("m register changed without a write");

   property p_tu_rst;
      $rose(reset_n_in) |-> tu_size_out == `S2VA_TU_RST;
   endproperty
   a_tu_rst: assert property (disable iff (1'b0) p_tu_rst)
      else $error("transfer unit size not 64 after reset");

   property p_tu_even;
      tu_size_out[0] == 1'b0;
   endproperty
   a_tu_even: assert property (p_tu_even)
      else $error("transfer unit size became odd");

   property p_pol_zero;
      s_rd_pol |=> reg_rdata_out[31:2] == 30'h0;
   endproperty
   a_pol_zero: assert property (p_pol_zero)
      else $error("undefined polarity bits read nonzero");

   property p_idle_zero;
      !reg_rd_in |=> reg_rdata_out == 32'h0000_0000;
   endproperty
   a_idle_zero: assert property (p_idle_zero)
      else $error("read data not zero outside a read answer");

   property p_rst_zero;
      $rose(reset_n_in) |-> hsync_width_out == '0 && m_link_out == '0;
   endproperty
   a_rst_zero: assert property (disable iff (1'b0) p_rst_zero)
      else $error("register not zero after reset");

   property p_vres_wr;
      wr_at(`S2VA_OFS_VRES)
         |=> active_height_out == $past(reg_wdata_in[`S2VA_RES_W-1:0]);
   endproperty
   a_vres_wr: assert property (p_vres_wr)
      else $error("active height not taken from write");

   property p_m_wr;
      wr_at(`S2VA_OFS_M)
         |=> clock_ratio_m_out == $past(reg_wdata_in[`S2VA_M_W-1:0]);
   endproperty
   a_m_wr: assert property (p_m_wr)
      else $error("m register not taken from write");

   sequence s_wr_m;
      wr_at(`S2VA_OFS_M);
   endsequence

   sequence s_rd_m;
      rd_at(`S2VA_OFS_M);
   endsequence

   // readback gives the software value, whatever the selector uses
   property p_m_rd;
      s_wr_m ##1 s_rd_m
         |=> reg_rdata_out == 32'($past(reg_wdata_in[`S2VA_M_W-1:0], 2));
   endproperty
   a_m_rd: assert property (p_m_rd)
      else $error("m readback differs from programmed value");

   property p_tu_wr;
      wr_at(`S2VA_OFS_TU)
         |=> tu_size_out ==
             {$past(reg_wdata_in[`S2VA_TU_W-1:1]), 1'b0};
   endproperty
   a_tu_wr: assert property (p_tu_wr)
      else $error("transfer unit size not taken from write");

   // reads off the word grid hit no register and must answer zero
   property p_odd_rd;
      reg_rd_in && (reg_addr_in[1:0] != '0)
         |=> reg_rdata_out == 32'h0000_0000;
   endproperty
   a_odd_rd: assert property (p_odd_rd)
      else $error("misaligned read answered nonzero");
endmodule
`default_nettype wire

// *** rtl/s2va_defs.svh ***
// Overview of operation
// - polarity bit 1 sets vsync active level
// - polarity bit 0 sets hsync active level
// - 15-bit hsync width in clocks
// - 15-bit vsync width in lines
// - 16-bit active pixels per line
// - 16-bit active lines per frame
// - 16-bit clocks from hsync to active
// - 16-bit lines from vsync to active
// - attribute byte a field layout
// - attribute byte b field layout
// - computed m never written back to register
// - transfer unit size resets to 64
// - size bit 0 ignores writes, stays even
`ifndef S2VA_DEFS_SVH
`define S2VA_DEFS_SVH
// byte offsets of the bank
`define S2VA_OFS_POL   12'h508
`define S2VA_OFS_HSW   12'h50C
`define S2VA_OFS_VSW   12'h510
`define S2VA_OFS_HRES  12'h514
`define S2VA_OFS_VRES  12'h518
`define S2VA_OFS_HST   12'h51C
`define S2VA_OFS_VST   12'h520
`define S2VA_OFS_ATA   12'h524
`define S2VA_OFS_ATB   12'h528
`define S2VA_OFS_M     12'h52C
`define S2VA_OFS_TU    12'h530
`define S2VA_OFS_W     12
// register indices after decode
`define S2VA_IDX_POL   4'h0
`define S2VA_IDX_HSW   4'h1
`define S2VA_IDX_VSW   4'h2
`define S2VA_IDX_HRES  4'h3
`define S2VA_IDX_VRES  4'h4
`define S2VA_IDX_HST   4'h5
`define S2VA_IDX_VST   4'h6
`define S2VA_IDX_ATA   4'h7
`define S2VA_IDX_ATB   4'h8
`define S2VA_IDX_M     4'h9
`define S2VA_IDX_TU    4'hA
// field positions and widths
`define S2VA_VPOL_BIT  1
`define S2VA_HPOL_BIT  0
`define S2VA_SYNC_BIT  0
`define S2VA_SW_W      15
`define S2VA_RES_W     16
`define S2VA_ATA_W     8
`define S2VA_ATB_W     7
`define S2VA_M_W       24
`define S2VA_TU_W      7
// reset value of the transfer unit size
`define S2VA_TU_RST    7'h40
`endif

// *** rtl/s2va_pkg.sv ***
`include "s2va_defs.svh"
package s2va_pkg;
   // whole register bank plus read data, registered as one word
   typedef struct packed {
      logic                   vpol;   // vsync polarity
      logic                   hpol;   // hsync polarity
      logic [`S2VA_SW_W-1:0]  hsw;    // hsync width
      logic [`S2VA_SW_W-1:0]  vsw;    // vsync width
      logic [`S2VA_RES_W-1:0] hres;   // active pixels
      logic [`S2VA_RES_W-1:0] vres;   // active lines
      logic [`S2VA_RES_W-1:0] hst;    // horizontal start
      logic [`S2VA_RES_W-1:0] vst;    // vertical start
      logic [`S2VA_ATA_W-1:0] ata;    // attribute byte a
      logic [`S2VA_ATB_W-1:0] atb;    // attribute byte b
      logic [`S2VA_M_W-1:0]   m;      // programmed m value
      logic [`S2VA_TU_W-1:0]  tu;     // transfer unit size
      logic [31:0]            rdata;  // read answer
   } s2va_bank_t;
   // state of the m selector
   typedef struct packed {
      logic [`S2VA_M_W-1:0] m;        // m sent to the framer
   } s2va_msel_t;
   // offset to {hit, index}
   function automatic logic [4:0] s2va_decode(
      input logic [`S2VA_OFS_W-1:0] a);
      unique case (a)
         `S2VA_OFS_POL:  s2va_decode = {1'b1, `S2VA_IDX_POL};
         `S2VA_OFS_HSW:  s2va_decode = {1'b1, `S2VA_IDX_HSW};
         `S2VA_OFS_VSW:  s2va_decode = {1'b1, `S2VA_IDX_VSW};
         `S2VA_OFS_HRES: s2va_decode = {1'b1, `S2VA_IDX_HRES};
         `S2VA_OFS_VRES: s2va_decode = {1'b1, `S2VA_IDX_VRES};
         `S2VA_OFS_HST:  s2va_decode = {1'b1, `S2VA_IDX_HST};
         `S2VA_OFS_VST:  s2va_decode = {1'b1, `S2VA_IDX_VST};
         `S2VA_OFS_ATA:  s2va_decode = {1'b1, `S2VA_IDX_ATA};
         `S2VA_OFS_ATB:  s2va_decode = {1'b1, `S2VA_IDX_ATB};
         `S2VA_OFS_M:    s2va_decode = {1'b1, `S2VA_IDX_M};
         `S2VA_OFS_TU:   s2va_decode = {1'b1, `S2VA_IDX_TU};
         default:        s2va_decode = 5'h00;
      endcase
   endfunction
endpackage

// *** rtl/s2va_acc_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// decoded register access between decoder and bank
interface s2va_acc_if;
   logic        wr;     // write to a mapped register
   logic        rd;     // read of a mapped register
   logic [3:0]  idx;    // register index
   logic [31:0] wdata;  // write data
   modport dec  (output wr, rd, idx, wdata);
   modport bank (input  wr, rd, idx, wdata);
endinterface
`default_nettype wire

// *** rtl/s2va_addr_dec.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "s2va_defs.svh"
module s2va_addr_dec
   import s2va_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input  wire logic [ADDR_W-1:0] addr_in,   // byte address
   input  wire logic              wr_in,     // write strobe
   input  wire logic              rd_in,     // read strobe
   input  wire logic [31:0]       wdata_in,  // write data
   s2va_acc_if.dec                acc        // decoded access
);
   logic [4:0] dec_w;   // {hit, index}
   logic       upper_w; // address bits above the bank are zero

   // unmapped addresses give no strobe, so reads of them answer zero
   always_comb begin
      upper_w   = ((addr_in >> `S2VA_OFS_W) == '0);
      dec_w     = s2va_decode(addr_in[`S2VA_OFS_W-1:0]);
      acc.wr    = wr_in && upper_w && dec_w[4];
      acc.rd    = rd_in && upper_w && dec_w[4];
      acc.idx   = dec_w[3:0];
      acc.wdata = wdata_in;
   end
endmodule
`default_nettype wire

// *** rtl/s2va_mval_sel.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "s2va_defs.svh"
module s2va_mval_sel
   import s2va_pkg::*;
(
   input  wire logic                 clk_in,     // core clock
   input  wire logic                 rst_n_in,   // async reset
   input  wire logic                 sync_in,    // synchronous clocking
   input  wire logic [`S2VA_M_W-1:0] m_reg_in,   // programmed m
   input  wire logic [`S2VA_M_W-1:0] m_calc_in,  // computed m
   output logic      [`S2VA_M_W-1:0] m_link_out  // m for the stream
);
   s2va_msel_t st_ff;   // selector state
   s2va_msel_t nxt_st;  // next state

   // only this path sees the computed value, never the register
   always_comb begin
      nxt_st   = st_ff;
      nxt_st.m = sync_in ? m_reg_in : m_calc_in;
   end

   // registered so the framer sees a glitch-free word
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign m_link_out = st_ff.m;
endmodule
`default_nettype wire

// *** testbench/stream2_video_attr_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "s2va_defs.svh"
// self-checking bench: integer model of the bank against the design
module stream2_video_attr_regs_tb;
   logic        core_clk_in;        // 50 MHz clock
   logic        reset_n_in;         // async reset, active low
   logic [11:0] reg_addr_in;        // byte address
   logic [31:0] reg_wdata_in;       // write data
   logic        reg_wr_in;          // write strobe
   logic        reg_rd_in;          // read strobe
   logic [31:0] reg_rdata_out;      // read answer
   logic [23:0] m_calc_in;          // computed m from outside
   logic        vsync_pol_out;      // vsync level
   logic        hsync_pol_out;      // hsync level
   logic [14:0] hsync_width_out;    // hsync width
   logic [14:0] vsync_width_out;    // vsync width
   logic [15:0] active_width_out;   // active pixels
   logic [15:0] active_height_out;  // active lines
   logic [15:0] h_offset_out;       // horizontal start
   logic [15:0] v_offset_out;       // vertical start
   logic [7:0]  attr_byte_a_out;    // attribute byte a
   logic [7:0]  attr_byte_b_out;    // attribute byte b
   logic [23:0] clock_ratio_m_out;  // programmed m
   logic [23:0] m_link_out;         // m in use
   logic [6:0]  tu_size_out;        // transfer unit size
   // model state: stored words, expected read and link m
   logic [31:0] mdl [11];           // register contents
   logic [31:0] rexp;               // read data due this cycle
   logic [23:0] mlink_exp;          // link m due this cycle
   int          miscompares;        // mismatches seen
   int          cmp_count;          // comparisons made
   // writable bits per register, in offset order
   logic [31:0] mask [11] = '{32'h3, 32'h7FFF, 32'h7FFF, 32'hFFFF,
      32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFF, 32'h7F, 32'hFFFFFF, 32'h7E};

   s2va_bank #(.ADDR_W(12)) DUT (
      .core_clk_in       (core_clk_in),
      .reset_n_in        (reset_n_in),
      .reg_addr_in       (reg_addr_in),
      .reg_wdata_in      (reg_wdata_in),
      .reg_wr_in         (reg_wr_in),
      .reg_rd_in         (reg_rd_in),
      .reg_rdata_out     (reg_rdata_out),
      .m_calc_in         (m_calc_in),
      .vsync_pol_out     (vsync_pol_out),
      .hsync_pol_out     (hsync_pol_out),
      .hsync_width_out   (hsync_width_out),
      .vsync_width_out   (vsync_width_out),
      .active_width_out  (active_width_out),
      .active_height_out (active_height_out),
      .h_offset_out      (h_offset_out),
      .v_offset_out      (v_offset_out),
      .attr_byte_a_out   (attr_byte_a_out),
      .attr_byte_b_out   (attr_byte_b_out),
      .clock_ratio_m_out (clock_ratio_m_out),
      .m_link_out        (m_link_out),
      .tu_size_out       (tu_size_out)
   );

   // free-running clock, 20 ns period
   initial begin
      core_clk_in = 1'b0;
      forever #10 core_clk_in = ~core_clk_in;
   end

   // byte address of register i
   function automatic logic [11:0] adr(input int i);
      adr = `S2VA_OFS_POL + 12'(i * 4);
   endfunction

   // all field outputs as the model predicts them
   function automatic logic [191:0] fexp();
      fexp = 192'({mdl[0][1], mdl[0][0], mdl[1][14:0], mdl[2][14:0],
         mdl[3][15:0], mdl[4][15:0], mdl[5][15:0], mdl[6][15:0],
         mdl[7][7:0], mdl[8][7:0], mdl[9][23:0], mlink_exp,
         mdl[10][6:0]});
   endfunction

   // all field outputs as the design shows them
   function automatic logic [191:0] fgot();
      fgot = 192'({vsync_pol_out, hsync_pol_out, hsync_width_out,
         vsync_width_out, active_width_out, active_height_out,
         h_offset_out, v_offset_out, attr_byte_a_out, attr_byte_b_out,
         clock_ratio_m_out, m_link_out, tu_size_out});
   endfunction

   // one comparison; four-state equality so an unknown matches only an unknown
   task automatic chk(input string nm, input logic [191:0] e, g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   // one bus cycle; called right after a rising edge
   task automatic bus(input logic w, r, input logic [11:0] a,
                      input logic [31:0] d);
      int          i;
      logic        hit;
      logic [23:0] mc;
      logic [23:0] mnxt;
      hit = a >= 12'h508 && a <= 12'h530 && a[1:0] == 2'h0;
      i = hit ? int'((a - 12'h508) >> 2) : 0;
      mc = 24'($urandom);
      // the selector sees the register values from before this edge
      mnxt = mdl[7][0] ? mdl[9][23:0] : mc;
      reg_wr_in <= w;
      reg_rd_in <= r;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      m_calc_in <= mc;
      @(posedge core_clk_in);
      #1;
      // the answer to this read stands now, and only now
      rexp = (r && hit) ? mdl[i] : 32'h0;
      chk("rdata", 192'(rexp), 192'(reg_rdata_out));
      // unmapped writes and bits outside the fields are dropped
      if (w && hit) mdl[i] = d & mask[i];
      mlink_exp = mnxt;
      chk("fields", fexp(), fgot());
   endtask

   // reset for five edges, checking values while it is held
   task automatic do_reset();
      reset_n_in <= 1'b0;
      reg_wr_in <= 1'b0;
      reg_rd_in <= 1'b0;
      @(posedge core_clk_in);
      #1;
      foreach (mdl[k]) mdl[k] = 32'h0;
      mdl[10] = 32'h40;
      rexp = 32'h0;
      mlink_exp = 24'h0;
      chk("rdata", 192'(rexp), 192'(reg_rdata_out));
      chk("fields", fexp(), fgot());
      repeat (4) @(posedge core_clk_in);
      reset_n_in <= 1'b1;
   endtask

   // read every register back to back
   task automatic read_all();
      for (int i = 0; i < 11; i++) bus(1'b0, 1'b1, adr(i), 32'h0);
   endtask

   // single place where the run ends
   task automatic print_verdict();
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // guard against a hang of the main sequence
   initial begin
      repeat (20000) @(posedge core_clk_in);
      miscompares++;
      print_verdict();
   end

   // main sequence
   initial begin
      reset_n_in = 1'b0;
      reg_addr_in = 12'h0;
      reg_wdata_in = 32'h0;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      m_calc_in = 24'h0;
      miscompares = 0;
      cmp_count = 0;
      void'($urandom(32'hF382DA8F));
      @(posedge core_clk_in);
      do_reset();
      read_all();
      // random data, each write read back in the very next cycle
      for (int k = 0; k < 3; k++) begin
         for (int i = 0; i < 11; i++) begin
            bus(1'b1, 1'b0, adr(i), $urandom);
            bus(1'b0, 1'b1, adr(i), 32'h0);
         end
      end
      // all ones: undefined bits and the size lsb must stay clear
      for (int i = 0; i < 11; i++) begin
         bus(1'b1, 1'b0, adr(i), 32'hFFFFFFFF);
         bus(1'b0, 1'b1, adr(i), 32'h0);
      end
      // whole legal size range, odd values included
      for (int v = 32; v <= 64; v++) begin
         bus(1'b1, 1'b0, `S2VA_OFS_TU, 32'(v));
         bus(1'b0, 1'b1, `S2VA_OFS_TU, 32'h0);
      end
      // holes and neighbours of the map change nothing, read zero
      foreach (mask[i]) begin
         bus(1'b1, 1'b0, adr(i) + 12'h2, $urandom);
         bus(1'b0, 1'b1, adr(i) + 12'h1, 32'h0);
      end
      bus(1'b1, 1'b0, 12'h504, $urandom);
      bus(1'b0, 1'b1, 12'h534, 32'h0);
      bus(1'b0, 1'b1, 12'hFFC, 32'h0);
      // synchronous flag toggled; link m follows the right source
      for (int k = 0; k < 8; k++) begin
         bus(1'b1, 1'b0, `S2VA_OFS_ATA,
             32'({$urandom, 1'(k)}) & 32'hFF);
         bus(1'b1, 1'b0, `S2VA_OFS_M, $urandom);
         repeat (3) bus(1'b0, 1'b0, 12'h0, 32'h0);
         bus(1'b0, 1'b1, `S2VA_OFS_M, 32'h0);
      end
      // reset in mid-run restores the defaults
      do_reset();
      read_all();
      bus(1'b0, 1'b0, 12'h0, 32'h0);
      print_verdict();
   end
endmodule
`default_nettype wire
